//--- word_fifo.sv
module word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);

  // Pointers wrap naturally, so DEPTH must be a power of two.
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wrPtr;
    logic [PW-1:0]               rdPtr;
    logic [PW:0]                 count;
  } fifo_t;

  fifo_t f;
  fifo_t next_f;
  logic  doPush;
  logic  doPop;

  assign inReady  = (f.count != DEPTH[PW:0]);
  assign outValid = (f.count != '0);
  assign outData  = f.mem[f.rdPtr];
  assign doPush   = inValid && inReady;
  assign doPop    = outValid && outReady;

  always_comb
  begin
    next_f = f;
    if (doPush)
    begin
      next_f.mem[f.wrPtr] = inData;
      next_f.wrPtr        = f.wrPtr + 1'b1;
    end
    if (doPop)
    begin
      next_f.rdPtr = f.rdPtr + 1'b1;
    end
    if (doPush && !doPop)
    begin
      next_f.count = f.count + 1'b1;
    end
    else if (doPop && !doPush)
    begin
      next_f.count = f.count - 1'b1;
    end
    if (rst)
    begin
      next_f.wrPtr = '0;
      next_f.rdPtr = '0;
      next_f.count = '0;
    end
  end

  always_ff @(posedge clk)
  begin
    f <= next_f;
  end

endmodule : word_fifo

//--- scan_address_select.sv
// How it works
// - Scan registers load at MSB, shift out LSB.
// - Direct-addressed device drives serial output normally.
// - Interrogate code: complement address, strong zeros.
// - Broadcast or group selection keeps output floating.
// - Only seven address bits are compared.
// - Test-Logic-Reset returns to waiting for address.
// - Return-to-wait instruction returns to waiting.
// - Update-IR compares bits 6..0 with slot.
// - Selection puts identification register in path.
// - Mismatch leaves device unselected until wait.
// - Broadcast code selects every waiting device.
// - Broadcast signatures read back by direct addressing.
// - Group membership register holds one of four.
// - Group code selects members, output stays floating.
// - Unselected shifting discards bits, never drives output.
package scan_select_pkg;

  localparam int          IR_WIDTH          = 8;
  localparam int          ADDR_WIDTH        = 7;
  localparam int          ID_WIDTH          = 32;
  localparam int          GROUP_WIDTH       = 2;
  localparam int          FIFO_DEPTH        = 4;
  localparam logic [6:0]  ADDR_INTERROGATE  = 7'h3A;
  localparam logic [6:0]  BROADCAST_DEFAULT = 7'h3B;
  localparam logic [6:0]  GROUP0_DEFAULT    = 7'h3C;
  localparam logic [6:0]  GROUP1_DEFAULT    = 7'h3D;
  localparam logic [6:0]  GROUP2_DEFAULT    = 7'h3E;
  localparam logic [6:0]  GROUP3_DEFAULT    = 7'h3F;
  localparam logic [7:0]  OP_RETURN_TO_WAIT = 8'hC3;
  localparam logic [7:0]  OP_GROUP_SEL      = 8'h03;
  localparam logic [7:0]  OP_BYPASS         = 8'hFF;
  localparam logic [7:0]  OP_IDCODE         = 8'hAA;
  localparam logic [7:0]  IR_CAPTURE        = 8'h01;
  localparam logic [1:0]  GROUP_RESET       = 2'h0;
  // Identification value is arbitrary; bit 0 is set as scan convention asks.
  localparam logic [31:0] ID_DEFAULT        = 32'h0A5C_0001;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
    TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
    TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } tap_state_t;

  typedef enum logic [2:0] {
    SEL_WAIT, SEL_SINGLE, SEL_GROUP, SEL_INTERROGATE, SEL_UNSELECTED
  } sel_state_t;

  typedef enum logic [1:0] {
    DR_ID, DR_GROUP, DR_BYPASS, DR_SLOT
  } dr_kind_t;

  function automatic tap_state_t tapNext(input tap_state_t s, input logic tms);
    tap_state_t n;
    n = s;
    case (s)
      TAP_RESET:    n = tms ? TAP_RESET    : TAP_IDLE;
      TAP_IDLE:     n = tms ? TAP_SEL_DR   : TAP_IDLE;
      TAP_SEL_DR:   n = tms ? TAP_SEL_IR   : TAP_CAP_DR;
      TAP_CAP_DR:   n = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: n = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: n = tms ? TAP_UPD_DR   : TAP_PAUSE_DR;
      TAP_PAUSE_DR: n = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: n = tms ? TAP_UPD_DR   : TAP_SHIFT_DR;
      TAP_UPD_DR:   n = tms ? TAP_SEL_DR   : TAP_IDLE;
      TAP_SEL_IR:   n = tms ? TAP_RESET    : TAP_CAP_IR;
      TAP_CAP_IR:   n = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: n = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: n = tms ? TAP_UPD_IR   : TAP_PAUSE_IR;
      TAP_PAUSE_IR: n = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: n = tms ? TAP_UPD_IR   : TAP_SHIFT_IR;
      TAP_UPD_IR:   n = tms ? TAP_SEL_DR   : TAP_IDLE;
      default:      n = TAP_RESET;
    endcase
    return n;
  endfunction : tapNext

  // Picks the data register that sits between the serial input and output.
  function automatic dr_kind_t drSelect(input sel_state_t sel, input logic [7:0] instr);
    dr_kind_t k;
    k = DR_BYPASS;
    if (sel == SEL_INTERROGATE)
    begin
      k = DR_SLOT;
    end
    else if (sel == SEL_SINGLE && instr == OP_GROUP_SEL)
    begin
      k = DR_GROUP;
    end
    else if ((sel == SEL_SINGLE || sel == SEL_GROUP) && instr != OP_BYPASS)
    begin
      k = DR_ID;
    end
    return k;
  endfunction : drSelect

  // New bit enters at the register's top bit; bit 0 leaves toward the output.
  function automatic logic [31:0] shiftIn(input logic [31:0] v, input logic b,
                                          input dr_kind_t k);
    logic [31:0] r;
    r = '0;
    case (k)
      DR_ID:     r = {b, v[31:1]};
      DR_GROUP:  r = {30'h0000_0000, b, v[1]};
      DR_SLOT:   r = {25'h000_0000, b, v[6:1]};
      default:   r = {31'h0000_0000, b};
    endcase
    return r;
  endfunction : shiftIn

endpackage : scan_select_pkg

module scan_address_select
  import scan_select_pkg::*;
#(
  parameter logic [6:0]  BROADCAST_CODE = BROADCAST_DEFAULT,
  parameter logic [6:0]  GROUP0_CODE    = GROUP0_DEFAULT,
  parameter logic [6:0]  GROUP1_CODE    = GROUP1_DEFAULT,
  parameter logic [6:0]  GROUP2_CODE    = GROUP2_DEFAULT,
  parameter logic [6:0]  GROUP3_CODE    = GROUP3_DEFAULT,
  parameter logic [31:0] ID_CODE        = ID_DEFAULT
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       tck,
  input  wire logic       tms,
  input  wire logic       tdi,
  input  wire logic [6:0] slotAddr,
  output logic            tdoOut,
  output logic            tdoOe,
  output logic            tdoWeakHigh,
  output logic            wordValid,
  input  wire logic       wordReady,
  output logic      [7:0] wordData,
  output logic            isSingle,
  output logic            isGroup
);

  // Logic on the scan clock.
  typedef struct packed {
    logic       rstS1;
    logic       rstS2;
    logic [6:0] slotS1;
    logic [6:0] slotS2;
    logic       ackS1;
    logic       ackS2;
    tap_state_t tap;
    sel_state_t sel;
    logic [7:0] irShift;
    logic [7:0] instr;
    logic [31:0] dr;
    logic [1:0] groupReg;
    logic       tdo;
    logic       tdoOe;
    logic       tdoWeak;
    logic [7:0] holdWord;
    logic       reqTog;
    logic       selSingle;
    logic       selGroup;
  } link_t;

  // Logic on the system clock.
  typedef struct packed {
    logic       reqS1;
    logic       reqS2;
    logic       reqSeen;
    logic [1:0] selS1;
    logic [1:0] selS2;
  } host_t;

  link_t      lk;
  link_t      next_lk;
  host_t      hs;
  host_t      next_hs;
  logic       pushValid;
  logic       pushReady;
  logic       shifting;
  logic       outBit;
  dr_kind_t   kind;

  function automatic logic groupHit(input logic [6:0] a, input logic [1:0] g);
    logic hit;
    hit = 1'b0;
    if (a == GROUP0_CODE && g == 2'h0)
    begin
      hit = 1'b1;
    end
    else if (a == GROUP1_CODE && g == 2'h1)
    begin
      hit = 1'b1;
    end
    else if (a == GROUP2_CODE && g == 2'h2)
    begin
      hit = 1'b1;
    end
    else if (a == GROUP3_CODE && g == 2'h3)
    begin
      hit = 1'b1;
    end
    return hit;
  endfunction : groupHit

  assign kind = drSelect(lk.sel, lk.instr);

  always_comb
  begin
    next_lk        = lk;
    next_lk.rstS1  = rst;
    next_lk.rstS2  = lk.rstS1;
    next_lk.slotS1 = slotAddr;
    next_lk.slotS2 = lk.slotS1;
    next_lk.ackS1  = hs.reqSeen;
    next_lk.ackS2  = lk.ackS1;
    next_lk.tap    = tapNext(lk.tap, tms);
    shifting       = 1'b0;
    outBit         = 1'b0;

    case (lk.tap)
      TAP_CAP_IR:
      begin
        next_lk.irShift = IR_CAPTURE;
      end
      TAP_SHIFT_IR:
      begin
        // Unselected devices lose the bit leaving bit 0.
        next_lk.irShift = {tdi, lk.irShift[7:1]};
      end
      TAP_UPD_IR:
      begin
        if (lk.sel == SEL_WAIT)
        begin
          // Bit 7 is a don't-care, so upper codes alias the lower range.
          if (lk.irShift[6:0] == lk.slotS2)
          begin
            next_lk.sel   = SEL_SINGLE;
            next_lk.instr = OP_IDCODE;
          end
          else if (lk.irShift[6:0] == ADDR_INTERROGATE)
          begin
            next_lk.sel = SEL_INTERROGATE;
          end
          else if (lk.irShift[6:0] == BROADCAST_CODE)
          begin
            next_lk.sel   = SEL_GROUP;
            next_lk.instr = OP_IDCODE;
          end
          else if (groupHit(lk.irShift[6:0], lk.groupReg))
          begin
            next_lk.sel   = SEL_GROUP;
            next_lk.instr = OP_IDCODE;
          end
          else
          begin
            next_lk.sel = SEL_UNSELECTED;
          end
        end
        else if (lk.irShift == OP_RETURN_TO_WAIT)
        begin
          next_lk.sel   = SEL_WAIT;
          next_lk.instr = OP_IDCODE;
        end
        else if (lk.sel == SEL_SINGLE || lk.sel == SEL_GROUP)
        begin
          next_lk.instr = lk.irShift;
        end
        // Instruction words taken while selected are handed to the system side.
        // A word that arrives while the previous one is still in flight is lost.
        if ((lk.sel == SEL_SINGLE || lk.sel == SEL_GROUP) && lk.reqTog == lk.ackS2)
        begin
          next_lk.holdWord = lk.irShift;
          next_lk.reqTog   = ~lk.reqTog;
        end
      end
      TAP_CAP_DR:
      begin
        case (kind)
          DR_ID:     next_lk.dr = ID_CODE;
          DR_GROUP:  next_lk.dr = {30'h0000_0000, lk.groupReg};
          DR_SLOT:   next_lk.dr = {25'h000_0000, ~lk.slotS2};
          default:   next_lk.dr = '0;
        endcase
      end
      TAP_SHIFT_DR:
      begin
        next_lk.dr = shiftIn(lk.dr, tdi, kind);
      end
      TAP_UPD_DR:
      begin
        // The group register is reachable only while singly selected.
        if (kind == DR_GROUP)
        begin
          next_lk.groupReg = lk.dr[1:0];
        end
      end
      default:
      begin
      end
    endcase

    if (lk.tap == TAP_RESET)
    begin
      next_lk.sel   = SEL_WAIT;
      next_lk.instr = OP_IDCODE;
    end

    // The output flop changes after the rising edge, so the tester sees each
    // bit at the following rising edge, as with a falling-edge output.
    if (next_lk.tap == TAP_SHIFT_IR)
    begin
      shifting = 1'b1;
      outBit   = next_lk.irShift[0];
    end
    else if (next_lk.tap == TAP_SHIFT_DR)
    begin
      shifting = 1'b1;
      outBit   = next_lk.dr[0];
    end

    next_lk.tdo     = 1'b0;
    next_lk.tdoOe   = 1'b0;
    next_lk.tdoWeak = 1'b0;
    case (next_lk.sel)
      SEL_SINGLE:
      begin
        next_lk.tdo   = outBit;
        next_lk.tdoOe = shifting;
      end
      SEL_INTERROGATE:
      begin
        if (next_lk.tap == TAP_SHIFT_DR)
        begin
          // Zeros win on the shared line; ones only pull up weakly.
          next_lk.tdoOe   = ~outBit;
          next_lk.tdoWeak = outBit;
        end
      end
      SEL_GROUP:
      begin
        // Many boards share the line here, so the buffer never turns on.
        // Results are read back later by addressing each board alone.
        next_lk.tdoOe = 1'b0;
      end
      default:
      begin
        next_lk.tdoOe = 1'b0;
      end
    endcase

    next_lk.selSingle = (next_lk.sel == SEL_SINGLE);
    next_lk.selGroup  = (next_lk.sel == SEL_GROUP);

    if (lk.rstS2)
    begin
      next_lk.tap       = TAP_RESET;
      next_lk.sel       = SEL_WAIT;
      next_lk.irShift   = IR_CAPTURE;
      next_lk.instr     = OP_IDCODE;
      next_lk.dr        = '0;
      next_lk.groupReg  = GROUP_RESET;
      next_lk.tdo       = 1'b0;
      next_lk.tdoOe     = 1'b0;
      next_lk.tdoWeak   = 1'b0;
      next_lk.holdWord  = '0;
      next_lk.reqTog    = 1'b0;
      next_lk.selSingle = 1'b0;
      next_lk.selGroup  = 1'b0;
    end
  end

  always_ff @(posedge tck)
  begin
    lk <= next_lk;
  end

  assign tdoOut      = lk.tdo;
  assign tdoOe       = lk.tdoOe;
  assign tdoWeakHigh = lk.tdoWeak;

  // The hold word stays still until its toggle is answered, so the system
  // side may read it once the toggle has crossed.
  assign pushValid = (hs.reqS2 != hs.reqSeen);

  always_comb
  begin
    next_hs       = hs;
    next_hs.reqS1 = lk.reqTog;
    next_hs.reqS2 = hs.reqS1;
    next_hs.selS1 = {lk.selGroup, lk.selSingle};
    next_hs.selS2 = hs.selS1;
    // A full buffer withholds the answer, so the scan side drops later words until it comes.
    if (pushValid && pushReady)
    begin
      next_hs.reqSeen = hs.reqS2;
    end
    if (rst)
    begin
      next_hs.reqSeen = 1'b0;
      next_hs.reqS1   = 1'b0;
      next_hs.reqS2   = 1'b0;
      next_hs.selS1   = 2'h0;
      next_hs.selS2   = 2'h0;
    end
  end

  always_ff @(posedge clk)
  begin
    hs <= next_hs;
  end

  assign isSingle = hs.selS2[0];
  assign isGroup  = hs.selS2[1];

  word_fifo #(
    .WIDTH (IR_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_word_fifo (
    .clk      (clk),
    .rst      (rst),
    .inValid  (pushValid),
    .inReady  (pushReady),
    .inData   (lk.holdWord),
    .outValid (wordValid),
    .outReady (wordReady),
    .outData  (wordData)
  );

endmodule : scan_address_select

//--- scan_select_properties.sv
module scan_select_checker (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       tck,
  input wire logic       tms,
  input wire logic       tdoOe,
  input wire logic       tdoWeakHigh,
  input wire logic       wordValid,
  input wire logic       wordReady,
  input wire logic [7:0] wordData,
  input wire logic       isSingle,
  input wire logic       isGroup
);
  timeunit 1ns;
  timeprecision 100ps;

  weak_excl_a: assert property (@(posedge tck) disable iff (rst)
    tdoWeakHigh |-> !tdoOe) else $error("weak pull-up and strong drive together");
  group_float_a: assert property (@(posedge clk) disable iff (rst)
    isGroup |-> !tdoOe && !tdoWeakHigh) else $error("group selection drives serial output");
  sel_excl_a: assert property (@(posedge clk) disable iff (rst)
    !(isSingle && isGroup)) else $error("single and group selection together");
  // Five high mode bits always reach reset, so both flags must be clear two edges later.
  tlr_wait_a: assert property (@(posedge tck) disable iff (rst)
    tms [*5] |-> ##2 !isSingle && !isGroup) else $error("selection survived reset state");
  word_hold_a: assert property (@(posedge clk) disable iff (rst)
    wordValid && !wordReady |=> wordValid && $stable(wordData))
    else $error("unacknowledged word changed");
  oe_start_a: assert property (@(posedge tck) disable iff (rst)
    $rose(tdoOe) |-> !$past(tms)) else $error("drive began outside shift");
  weak_start_a: assert property (@(posedge tck) disable iff (rst)
    $rose(tdoWeakHigh) |-> !$past(tms)) else $error("weak drive began outside shift");
  oe_end_a: assert property (@(posedge tck) disable iff (rst)
    $fell(tdoOe) && !tdoWeakHigh |-> $past(tms)) else $error("drive ended inside shift");
endmodule : scan_select_checker

bind scan_address_select scan_select_checker checker_u (
  .clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdoOe(tdoOe), .tdoWeakHigh(tdoWeakHigh),
  .wordValid(wordValid), .wordReady(wordReady), .wordData(wordData),
  .isSingle(isSingle), .isGroup(isGroup)
);

//--- scan_tester.sv
module scan_tester (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdoOut,
  input  wire logic tdoOe,
  input  wire logic tdoWeakHigh
);
  timeunit 1ns;
  timeprecision 100ps;

  logic line;

  // A released backplane line is seen as floating, so a stray drive cannot pass unseen.
  assign line = tdoOe ? tdoOut : (tdoWeakHigh ? 1'b1 : 1'bz);

  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // The clock only runs inside a step, so it stands still between frames.
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #62.0;
    q = line;
    tck = 1'b1;
    #62.5;
    tck = 1'b0;
    #0.5;
  endtask : step

  task automatic resetTap();
    logic q;
    repeat (6) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask : resetTap

  task automatic scan(input logic ir, input int n, input logic [31:0] v,
                      output logic [31:0] o);
    logic q;
    o = '0;
    step(1'b1, 1'b0, q);
    if (ir)
    begin
      step(1'b1, 1'b0, q);
    end
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, v[i], q);
      o[i] = q;
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask : scan
endmodule : scan_tester

//--- tb.sv
module tb
  import scan_select_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [6:0] slotAddr = 7'h15; // Unique static strap, no reserved code.
  logic       wordReady = 1'b0;
  logic       tck, tms, tdi, tdoOut, tdoOe, tdoWeakHigh, wordValid, isSingle, isGroup;
  logic [7:0] wordData;
  int         failures = 0;
  int         checks = 0;

  always #10 clk = ~clk;

  scan_address_select dut_u (.clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi),
    .slotAddr(slotAddr), .tdoOut(tdoOut), .tdoOe(tdoOe), .tdoWeakHigh(tdoWeakHigh),
    .wordValid(wordValid), .wordReady(wordReady), .wordData(wordData),
    .isSingle(isSingle), .isGroup(isGroup));

  scan_tester tester (.tck(tck), .tms(tms), .tdi(tdi), .tdoOut(tdoOut), .tdoOe(tdoOe),
    .tdoWeakHigh(tdoWeakHigh));

  task automatic check(input logic [31:0] got, input logic [31:0] expv);
    checks++;
    if (got !== expv)
    begin
      failures++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, expv);
    end
  endtask : check

  task automatic ir(input logic [7:0] v, input logic [7:0] expOut);
    logic [31:0] o;
    tester.scan(1'b1, 8, {24'h0, v}, o);
    check(o, {24'h0, expOut});
  endtask : ir

  task automatic dr(input int n, input logic [31:0] v, input logic [31:0] expOut);
    logic [31:0] o;
    tester.scan(1'b0, n, v, o);
    check(o, expOut);
  endtask : dr

  task automatic flags(input logic s, input logic g);
    repeat (5) @(posedge clk);
    #2;
    check({30'h0, isSingle, isGroup}, {30'h0, s, g});
  endtask : flags

  task automatic pop(input logic [7:0] expv);
    int n;
    n = 0;
    // An edge always passes first, so back-to-back pops never set ready twice at once.
    do
    begin
      @(posedge clk);
      #2;
      n++;
    end
    while (wordValid !== 1'b1 && n < 20);
    check({23'h0, wordValid, wordData}, {23'h0, 1'b1, expv});
    wordReady = 1'b1;
    @(posedge clk);
    #2;
    wordReady = 1'b0;
  endtask : pop

  task automatic direct_select();
    ir(8'h95, 8'hZZ);
    flags(1'b1, 1'b0);
    dr(32, 32'h0, ID_DEFAULT);
    ir(OP_GROUP_SEL, IR_CAPTURE);
    pop(OP_GROUP_SEL);
    dr(2, 32'h2, 32'h0);
    // Group 2 is written again so that the first write reads back as 2; membership stays 2 for the group scenario.
    dr(2, 32'h2, 32'h2);
    ir(OP_BYPASS, IR_CAPTURE);
    pop(OP_BYPASS);
    dr(2, 32'h3, 32'h2);
    ir(OP_RETURN_TO_WAIT, IR_CAPTURE);
    pop(OP_RETURN_TO_WAIT);
    flags(1'b0, 1'b0);
  endtask : direct_select

  task automatic group_select();
    ir({1'b0, GROUP2_DEFAULT}, 8'hZZ);
    flags(1'b0, 1'b1);
    ir(OP_IDCODE, 8'hZZ);
    pop(OP_IDCODE);
    dr(32, 32'h0, 32'hZZZZ_ZZZZ);
    ir(OP_RETURN_TO_WAIT, 8'hZZ);
    pop(OP_RETURN_TO_WAIT);
    ir({1'b0, GROUP1_DEFAULT}, 8'hZZ);
    flags(1'b0, 1'b0);
    ir({1'b0, slotAddr}, 8'hZZ);
    flags(1'b0, 1'b0);
    ir(OP_RETURN_TO_WAIT, 8'hZZ);
    ir({1'b0, slotAddr}, 8'hZZ);
    flags(1'b1, 1'b0);
    tester.resetTap();
    flags(1'b0, 1'b0);
    ir({1'b0, BROADCAST_DEFAULT}, 8'hZZ);
    flags(1'b0, 1'b1);
    ir(8'hC9, 8'hZZ);
    pop(8'hC9);
    tester.resetTap();
    ir({1'b0, slotAddr}, 8'hZZ);
    flags(1'b1, 1'b0);
    tester.resetTap();
  endtask : group_select

  task automatic interrogate();
    ir({1'b0, ADDR_INTERROGATE}, 8'hZZ);
    dr(7, 32'h0, {25'h0, ~slotAddr});
    tester.resetTap();
  endtask : interrogate

  // The fifth word waits in the crossing while the buffer is full; the sixth is lost.
  task automatic fifo_fill();
    logic [7:0] w;
    ir({1'b0, slotAddr}, 8'hZZ);
    for (int i = 0; i < 6; i++)
    begin
      w = 8'h10 + 8'(i);
      ir(w, IR_CAPTURE);
    end
    for (int i = 0; i < 5; i++)
    begin
      w = 8'h10 + 8'(i);
      pop(w);
    end
    flags(1'b1, 1'b0);
    check({31'h0, wordValid}, 32'h0);
    tester.resetTap();
  endtask : fifo_fill

  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
    begin
      $display("Result: passed");
    end
    else
    begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop

  // The link domain only resets while its clock runs, so the tester clocks during reset.
  initial
  begin
    fork
      repeat (8) @(posedge clk);
      tester.resetTap();
    join
    @(posedge clk);
    #2;
    rst = 1'b0;
    tester.resetTap();
    direct_select();
    group_select();
    interrogate();
    fifo_fill();
    report_and_stop();
  end

  // The scenarios need about 60 us of scan clock, so this leaves a wide margin.
  initial
  begin
    #200000;
    failures++;
    report_and_stop();
  end
endmodule : tb
